// ==== hdl/dss_ctrl.sv ====
/*
 Debug state sequencer next-state control: registers, channel
 qualification and the five-state sequencer.
 Assumes comparators, arming and profiling status come from elsewhere,
 synchronous to clk.
*/
//
// Behaviour
// RL1: State1 selects from first control register
// RL2: State2 selects from second control register
// RL3: State3 selects from third control register
// RL4: State1 codes: none, State2, State3, Final
// RL5: State2 codes: none, State1, State3, Final
// RL6: State3 codes: none, State1, State2, Final
// RL7: Highest numbered matching channel wins
// RL8: Selector 10 routes external event to channel3
// RL9: Writes only disarmed and not profiling; reads anytime
// RL10: Only enabled comparators cause transitions
// RL11: Arming enters State1
// RL12: Blocked write changes nothing
`timescale 1ns/1ps
module dss_ctrl #(
  parameter int CHANNELS = 4
) (
  input  wire logic                       clk,
  input  wire logic                       srst,
  input  wire logic [dss_pkg::ADDR_W-1:0] addr,
  input  wire logic [dss_pkg::DATA_W-1:0] wdata,
  input  wire logic                       wr,
  input  wire logic                       rd,
  output logic      [dss_pkg::DATA_W-1:0] rdata,
  input  wire logic [dss_pkg::CHAN_N-1:0] match,
  input  wire logic [dss_pkg::CHAN_N-1:0] comp_enable,
  input  wire logic                       ext_event,
  input  wire logic [dss_pkg::EEV_W-1:0]  external_event_select,
  input  wire logic                       armed,
  input  wire logic                       arm_start,
  input  wire logic                       session_abort,
  input  wire logic                       profiling_active,
  output logic      [dss_pkg::CODE_W-1:0] sequencer_state_code
);
  import dss_pkg::*;

  // Field layout is fixed at four channels of two bits each
  if (CHANNELS != CHAN_N) begin : g_bad_channels
    $error("only four channels supported");
  end

  logic [DATA_W-1:0]  sel1;
  logic [DATA_W-1:0]  sel2;
  logic [DATA_W-1:0]  sel3;
  logic [DATA_W-1:0]  sel_cur;
  logic [CHAN_N-1:0]  hit;
  logic [FIELD_W-1:0] field;
  dss_state_t         state;
  dss_state_t         next_state;

  dss_regs u_regs (
    .clk     (clk),
    .srst    (srst),
    .addr    (addr),
    .wdata   (wdata),
    .wr      (wr),
    .rd      (rd),
    .wr_lock (armed || profiling_active), // RL9
    .rdata   (rdata),
    .sel1    (sel1),
    .sel2    (sel2),
    .sel3    (sel3)
  );

  // Channel 3 can be swapped to the external event
  always_comb begin
    hit = match & comp_enable; // RL10
    if (external_event_select == EEV_EXTERNAL) begin
      hit[CHAN_N-1] = ext_event; // RL8
    end
  end

  always_comb begin
    case (state)
      DSS_ST1: sel_cur = sel1; // RL1
      DSS_ST2: sel_cur = sel2; // RL2
      DSS_ST3: sel_cur = sel3; // RL3
      default: sel_cur = SEL_RESET;
    endcase
  end

  dss_pick u_pick (
    .hit   (hit),
    .sel   (sel_cur),
    .field (field)
  );

  function automatic dss_state_t decode(input dss_state_t cur,
                                        input logic [FIELD_W-1:0] f);
    dss_state_t r;
    r = cur;
    case (f)
      SEL_A:     r = (cur == DSS_ST1) ? DSS_ST2 : DSS_ST1;
      SEL_B:     r = (cur == DSS_ST3) ? DSS_ST2 : DSS_ST3;
      SEL_FINAL: r = DSS_FINAL;
      default:   r = cur;
    endcase
    return r;
  endfunction : decode

  always_comb begin
    next_state = state;
    case (state)
      DSS_ST1, DSS_ST2, DSS_ST3:
        next_state = decode(state, field); // RL4 RL5 RL6
      DSS_ST0, DSS_FINAL: next_state = state;
      default: next_state = DSS_ST0;
    endcase
  end

  // Software disarm keeps the last state; internal end returns to State0
  always_ff @(posedge clk) begin
    if (srst) begin
      state <= DSS_ST0;
    end else if (arm_start) begin
      state <= DSS_ST1; // RL11
    end else if (session_abort) begin
      state <= DSS_ST0;
    end else if (armed) begin
      state <= next_state;
    end
  end

  always_comb begin
    case (state)
      DSS_ST1:   sequencer_state_code = CODE_STATE1;
      DSS_ST2:   sequencer_state_code = CODE_STATE2;
      DSS_ST3:   sequencer_state_code = CODE_STATE3;
      DSS_FINAL: sequencer_state_code = CODE_FINAL;
      default:   sequencer_state_code = CODE_STATE0;
    endcase
  end

  arm_enter_a: assert property (@(posedge clk) disable iff (srst) // RL11
    arm_start |=> sequencer_state_code == CODE_STATE1)
    else $error("arming did not enter State1");

  s1_to_final_a: assert property (@(posedge clk) disable iff (srst) // RL4
    armed && !arm_start && !session_abort && state == DSS_ST1
    && field == SEL_FINAL |=> state == DSS_FINAL)
    else $error("State1 final code not taken");

  s2_to_s1_a: assert property (@(posedge clk) disable iff (srst) // RL5
    armed && !arm_start && !session_abort && state == DSS_ST2
    && field == SEL_A |=> state == DSS_ST1)
    else $error("State2 code 01 not to State1");

  s3_to_s2_a: assert property (@(posedge clk) disable iff (srst) // RL6
    armed && !arm_start && !session_abort && state == DSS_ST3
    && field == SEL_B |=> state == DSS_ST2)
    else $error("State3 code 10 not to State2");

  top_chan_a: assert property (@(posedge clk) disable iff (srst) // RL7
    hit[CHAN_N-1] |-> field == sel_cur[DATA_W-1 -: FIELD_W])
    else $error("channel 3 lost priority");

  no_hit_hold_a: assert property (@(posedge clk) disable iff (srst) // RL10
    armed && !arm_start && !session_abort && hit == '0 |=> $stable(state))
    else $error("state moved without a match");

  disabled_chan_a: assert property (@(posedge clk) disable iff (srst) // RL10
    !comp_enable[0] |-> !hit[0])
    else $error("disabled channel 0 counted");

  ext_route_a: assert property (@(posedge clk) disable iff (srst) // RL8
    external_event_select == EEV_EXTERNAL |-> hit[CHAN_N-1] == ext_event)
    else $error("external event not routed");

  s1_reg_a: assert property (@(posedge clk) disable iff (srst) // RL1
    state == DSS_ST1 |-> sel_cur == sel1)
    else $error("State1 uses wrong register");

  s2_reg_a: assert property (@(posedge clk) disable iff (srst) // RL2
    state == DSS_ST2 |-> sel_cur == sel2)
    else $error("State2 uses wrong register");

  s3_reg_a: assert property (@(posedge clk) disable iff (srst) // RL3
    state == DSS_ST3 |-> sel_cur == sel3)
    else $error("State3 uses wrong register");

  write_ok_a: assert property (@(posedge clk) disable iff (srst) // RL9
    wr && !armed && !profiling_active && addr == OFS_STATE2
    |=> sel2 == $past(wdata))
    else $error("allowed write not stored");
endmodule : dss_ctrl

// ==== hdl/dss_pick.sv ====
/*
 Priority pick of the winning channel field.
 Assumes match inputs are already enable-gated.
*/
`timescale 1ns/1ps
module dss_pick (
  input  wire logic [dss_pkg::CHAN_N-1:0] hit,
  input  wire logic [dss_pkg::DATA_W-1:0] sel,
  output logic      [dss_pkg::FIELD_W-1:0] field
);
  import dss_pkg::*;

  // Highest channel wins, scanned upward so later ones override
  always_comb begin
    field = SEL_NONE;
    for (int i = 0; i < CHAN_N; i++) begin
      if (hit[i]) field = sel[i*FIELD_W +: FIELD_W]; // RL1 RL7
    end
  end
endmodule : dss_pick

// ==== hdl/dss_pkg.sv ====
/*
 Shared constants for the debug state sequencer control block.
 Assumes a byte-addressed register port with 8-bit data.
*/
package dss_pkg;
  localparam int         ADDR_W        = 16;
  localparam int         DATA_W        = 8;
  localparam int         CHAN_N        = 4;
  localparam int         FIELD_W       = 2;
  localparam int         CODE_W        = 3;
  localparam int         EEV_W         = 2;
  localparam logic [15:0] OFS_STATE1   = 16'h0107;
  localparam logic [15:0] OFS_STATE2   = 16'h0108;
  localparam logic [15:0] OFS_STATE3   = 16'h0109;
  localparam logic [7:0]  SEL_RESET    = 8'h00;
  localparam logic [7:0]  UNMAPPED_RD  = 8'h00;
  localparam logic [1:0]  EEV_EXTERNAL = 2'h2;
  localparam logic [1:0]  SEL_NONE     = 2'h0;
  localparam logic [1:0]  SEL_A        = 2'h1;
  localparam logic [1:0]  SEL_B        = 2'h2;
  localparam logic [1:0]  SEL_FINAL    = 2'h3;
  localparam logic [2:0]  CODE_STATE0  = 3'h0;
  localparam logic [2:0]  CODE_STATE1  = 3'h1;
  localparam logic [2:0]  CODE_STATE2  = 3'h2;
  localparam logic [2:0]  CODE_STATE3  = 3'h3;
  localparam logic [2:0]  CODE_FINAL   = 3'h4;

  typedef enum logic [4:0] {
    DSS_ST0   = 5'h01,
    DSS_ST1   = 5'h02,
    DSS_ST2   = 5'h04,
    DSS_ST3   = 5'h08,
    DSS_FINAL = 5'h10
  } dss_state_t;
endpackage : dss_pkg

// ==== hdl/dss_regs.sv ====
/*
 Three state control registers with guarded write and registered read.
 Assumes one-cycle strobes on the register port, never both at once.
*/
`timescale 1ns/1ps
module dss_regs (
  input  wire logic                       clk,
  input  wire logic                       srst,
  input  wire logic [dss_pkg::ADDR_W-1:0] addr,
  input  wire logic [dss_pkg::DATA_W-1:0] wdata,
  input  wire logic                       wr,
  input  wire logic                       rd,
  input  wire logic                       wr_lock,
  output logic      [dss_pkg::DATA_W-1:0] rdata,
  output logic      [dss_pkg::DATA_W-1:0] sel1,
  output logic      [dss_pkg::DATA_W-1:0] sel2,
  output logic      [dss_pkg::DATA_W-1:0] sel3
);
  import dss_pkg::*;

  always_ff @(posedge clk) begin
    if (srst) begin
      sel1 <= SEL_RESET;
      sel2 <= SEL_RESET;
      sel3 <= SEL_RESET;
    end else if (wr && !wr_lock) begin // RL9 RL12
      if (addr == OFS_STATE1) sel1 <= wdata;
      if (addr == OFS_STATE2) sel2 <= wdata;
      if (addr == OFS_STATE3) sel3 <= wdata;
    end
  end

  // Reads are never gated by arming
  always_ff @(posedge clk) begin
    if (srst) begin
      rdata <= UNMAPPED_RD;
    end else if (rd) begin // RL9
      case (addr)
        OFS_STATE1: rdata <= sel1;
        OFS_STATE2: rdata <= sel2;
        OFS_STATE3: rdata <= sel3;
        default:    rdata <= UNMAPPED_RD;
      endcase
    end else begin
      rdata <= UNMAPPED_RD;
    end
  end

  locked_write_a: assert property (@(posedge clk) disable iff (srst) // RL12
    wr && wr_lock |=> $stable(sel1) && $stable(sel2) && $stable(sel3))
    else $error("register changed while locked");
endmodule : dss_regs

// ==== sim/dss_cmp_model.sv ====
/*
 Comparator match model on the far side of the sequencer control.
 Assumes fire requests change just after a rising edge of clk.
*/
`timescale 1ns/1ps
module dss_cmp_model (
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic [3:0] fire,
  output logic      [3:0] match
);
  // One cycle of latency, as real match logic has
  always_ff @(posedge clk) begin
    if (srst) begin
      match <= 4'h0;
    end else begin
      match <= fire;
    end
  end
endmodule : dss_cmp_model

// ==== sim/test_debug_state_sequencer_control.sv ====
/*
 Self-checking bench for the sequencer control block.
 Assumes the comparator model above and a 25 MHz clock.
*/
`timescale 1ns/1ps
module test_debug_state_sequencer_control;
  import dss_pkg::*;
  logic        clk, srst, wr, rd, armed, arm_start, ext, prof;
  logic [15:0] addr;
  logic [7:0]  wdata, rdata;
  logic [3:0]  fire, match, en;
  logic [1:0]  esel;
  logic [2:0]  code;
  int          failures, n_compared;

  dss_cmp_model dss_cmp_model_i (.clk(clk), .srst(srst), .fire(fire),
    .match(match));
  dss_ctrl dss_ctrl_i (.clk(clk), .srst(srst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .match(match),
    .comp_enable(en), .ext_event(ext), .external_event_select(esel),
    .armed(armed), .arm_start(arm_start), .session_abort(1'b0),
    .profiling_active(prof), .sequencer_state_code(code));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task wr_reg(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  task rd_chk(input logic [15:0] a, input logic [7:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, e);
  endtask : rd_chk

  // Match reaches the block one cycle after fire, state one cycle later
  task hit(input logic [3:0] m, input logic [2:0] e);
    @(posedge clk);
    fire <= m;
    @(posedge clk);
    fire <= 4'h0;
    @(posedge clk);
    #1 chk({5'h00, code}, {5'h00, e});
  endtask : hit

  task arm;
    @(posedge clk);
    armed <= 1'b1;
    arm_start <= 1'b1;
    @(posedge clk);
    arm_start <= 1'b0;
    #1 chk({5'h00, code}, {5'h00, CODE_STATE1});
  endtask : arm

  task t_regs;
    for (int i = 0; i < 3; i++) rd_chk(OFS_STATE1 + 16'(i), SEL_RESET);
    wr_reg(OFS_STATE1, 8'hE4);
    wr_reg(OFS_STATE2, 8'hD8);
    wr_reg(OFS_STATE3, 8'hC9);
    rd_chk(OFS_STATE1, 8'hE4);
    rd_chk(OFS_STATE2, 8'hD8);
    rd_chk(OFS_STATE3, 8'hC9);
    @(posedge clk);
    #1 chk(rdata, UNMAPPED_RD);
    rd_chk(16'h010A, UNMAPPED_RD);
    $display("Register test done");
  endtask : t_regs

  task t_lock;
    @(posedge clk);
    prof <= 1'b1;
    wr_reg(OFS_STATE1, 8'h00);
    rd_chk(OFS_STATE1, 8'hE4);
    @(posedge clk);
    prof <= 1'b0;
    armed <= 1'b1;
    wr_reg(OFS_STATE2, 8'h00);
    rd_chk(OFS_STATE2, 8'hD8);
    @(posedge clk);
    armed <= 1'b0;
    $display("Write lock test done");
  endtask : t_lock

  task t_seq;
    @(posedge clk);
    en <= 4'hF;
    arm;
    hit(4'h1, CODE_STATE1);
    hit(4'h3, CODE_STATE2);
    hit(4'h2, CODE_STATE3);
    hit(4'h6, CODE_STATE3);
    hit(4'h2, CODE_STATE2);
    @(posedge clk);
    en <= 4'h7;
    hit(4'h8, CODE_STATE2);
    @(posedge clk);
    en <= 4'hF;
    esel <= EEV_EXTERNAL;
    hit(4'h8, CODE_STATE2);
    @(posedge clk);
    ext <= 1'b1;
    @(posedge clk);
    ext <= 1'b0;
    #1 chk({5'h00, code}, {5'h00, CODE_FINAL});
    hit(4'h7, CODE_FINAL);
    arm;
    hit(4'h4, CODE_STATE3);
    hit(4'h1, CODE_STATE1);
    hit(4'h2, CODE_STATE2);
    hit(4'h4, CODE_STATE1);
    $display("Sequencer test done");
  endtask : t_seq

  task results;
    $display("Compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : results

  initial begin
    srst = 1'b1;
    {wr, rd, armed, arm_start, ext, prof} = 6'h00;
    addr = 16'h0000;
    wdata = 8'h00;
    fire = 4'h0;
    en = 4'h0;
    esel = 2'h0;
    failures = 0;
    n_compared = 0;
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    t_regs;
    t_lock;
    t_seq;
    results;
  end

  // Whole run is near 85 cycles; this cuts a hang well past that
  initial begin
    #100000;
    failures++;
    results;
  end
endmodule : test_debug_state_sequencer_control
